// ==== rtl/upmc_pkg.sv ====
// Constants, register map and state type for the serial pin and mode control block.
package upmc_pkg;
    // Register byte offsets; channel B sits one stride above channel A.
    localparam logic [7:0] OFF_MODEM_CTRL = 8'h00;
    localparam logic [7:0] OFF_FEATURE = 8'h04;
    localparam logic [7:0] OFF_DIV_EXTRA = 8'h08;
    localparam logic [7:0] OFF_PIN_STATUS = 8'h0C;
    localparam logic [7:0] OFF_CHAN_STRIDE = 8'h10;
    localparam logic [7:0] OFF_SYS_STATUS = 8'h20;

    // Field positions in the modem control register.
    localparam int MCR_DTR = 0;
    localparam int MCR_RTS = 1;
    localparam int MCR_IRQ_EN = 3;
    localparam int MCR_IR_MODE = 6;
    // Field positions in the enhanced feature and divisor extra registers.
    localparam int EFR_AUTO_RTS = 6;
    localparam int EFR_AUTO_CTS = 7;
    localparam int DLD_RX_INV = 0;
    localparam int DLD_HDX = 6;
    // Field positions in the pin status register.
    localparam int PST_CTS = 0;
    localparam int PST_DSR = 1;
    localparam int PST_CD = 2;
    localparam int PST_RI = 3;
    localparam int PST_RX = 4;
    // Field positions in the system status register.
    localparam int SYS_STROBE_PAIR = 0;
    localparam int SYS_DEV_RST = 1;

    // Reset values of the software registers.
    localparam logic [7:0] RST_MODEM_CTRL = 8'h00;
    localparam logic [7:0] RST_FEATURE = 8'h00;
    localparam logic [7:0] RST_DIV_EXTRA = 8'h00;

    // Synchroniser bit positions; each modem group holds channel A then B.
    localparam int SY_CTS = 0;
    localparam int SY_DSR = 2;
    localparam int SY_CD = 4;
    localparam int SY_RI = 6;
    localparam int SY_RX = 8;
    localparam int SY_DEV_RST = 10;
    localparam int SY_BUS_SEL = 11;
    // Idle pin levels: modem lines high, receive high, reset low, bus select pulled high.
    localparam logic [11:0] SYNC_RST = 12'hBFF;

    // Shortest device reset pulse that is honoured.
    localparam int CLK_PERIOD_NS = 20;
    localparam int RST_MIN_NS = 40;
    localparam int RST_MIN_CYC_I = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] RST_MIN_CYC = 3'(RST_MIN_CYC_I);

    // Whole state of the block.
    typedef struct packed {
        logic [1:0][7:0] modem_control_reg;
        logic [1:0][7:0] enhanced_feature_reg;
        logic [1:0][7:0] divisor_extra_reg;
        logic [11:0] sync_m;
        logic [11:0] sync_s;
        logic [2:0] rst_cnt;
        logic dev_rst;
        logic strobe_pair;
        logic [1:0] tx;
        logic [1:0] rxd;
        logic [1:0] irq;
        logic [1:0] irq_oe;
        logic [1:0] gp_n;
        logic [1:0] rts_n;
        logic [1:0] dtr_n;
        logic [1:0] tx_permit;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } upmc_state_s;
endpackage

// ==== rtl/upmc_top.sv ====
// Pin and mode control of a dual serial channel, with an APB register slave.
`timescale 1ns/1ns
// How it works
// R1 - Interrupt enable bit set: interrupt pin driven, general output port low.
// R2 - Interrupt enable bit clear: interrupt pin released, general output port high.
// R3 - Software should not use the general output port while interrupts use it.
// R4 - Standard mode: transmit output high in reset and while idle.
// R5 - Infrared mode: encoder path used, transmit output rests low when idle.
// R6 - Remote party keeps receive input high when idle in standard mode.
// R7 - Software may invert the infrared receive input before the decoder.
// R8 - Software asserts request-to-send before relying on automatic flow control.
// R9 - Request-to-send doubles as half-duplex direction control when enabled.
// R10 - Clear-to-send is a general input and gates transmit when enabled.
// R11 - Terminal ready is an output; set ready, carrier, ring are inputs.
// R12 - Bus select high picks strobe-pair style, low picks direction-select style.
// R13 - Reset pin is active high in strobe-pair style, low otherwise.
// R14 - A reset pulse of minimum width returns registers and outputs to reset.
// R15 - During reset transmit outputs stay high and receive input is ignored.
// R16 - Reset and modem inputs are synchronised and reset releases on an edge.
module upmc_top
    import upmc_pkg::*;
(
    // Clock and block reset.
    input wire logic I_MCLK,
    input wire logic I_RESET_N,
    // APB slave.
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    // Device pins: bus select and device reset.
    input wire logic I_BUS_SEL,
    input wire logic I_DEV_RESET,
    // Per channel core side, index 0 is channel A.
    input wire logic [1:0] I_TX_BIT,
    input wire logic [1:0] I_TX_ACTIVE,
    input wire logic [1:0] I_IRQ_REQ,
    input wire logic [1:0] I_RX_HALT,
    output logic [1:0] O_RX_DATA,
    output logic [1:0] O_TX_PERMIT,
    // Per channel pins.
    output logic [1:0] O_SERIAL_OUT,
    input wire logic [1:0] I_SERIAL_IN,
    output logic [1:0] O_IRQ_OUT_CHAN,
    output logic [1:0] O_IRQ_OUT_CHAN_OE,
    output logic [1:0] O_GP_OUT_PORT_CHAN_N,
    output logic [1:0] O_REQUEST_TO_SEND_N,
    input wire logic [1:0] I_CLEAR_TO_SEND_N,
    output logic [1:0] O_TERMINAL_READY_N,
    input wire logic [1:0] I_SET_READY_N,
    input wire logic [1:0] I_CARRIER_DETECT_N,
    input wire logic [1:0] I_RING_INDICATOR_N,
    // Mode status.
    output logic O_BUS_STROBE_PAIR,
    output logic O_DEV_RESET_ACTIVE
);

    upmc_state_s st_q;
    upmc_state_s st_d;
    logic dev_pin_active;

    // Word aligned and inside the map.
    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a[1:0] == 2'b00) && ((a < OFF_SYS_STATUS) || (a == OFF_SYS_STATUS));
    endfunction

    // Read data for one address; unmapped addresses read as zero.
    function automatic logic [31:0] reg_read(input upmc_state_s s, input logic [7:0] a);
        logic c;
        logic [7:0] v;
        c = a[4];
        v = 8'h00;
        if (a == OFF_SYS_STATUS) begin
            v[SYS_STROBE_PAIR] = s.strobe_pair;
            v[SYS_DEV_RST] = s.dev_rst;
        end else if (a < OFF_SYS_STATUS) begin
            case (a[3:0])
                OFF_MODEM_CTRL[3:0]: v = s.modem_control_reg[c];
                OFF_FEATURE[3:0]: v = s.enhanced_feature_reg[c];
                OFF_DIV_EXTRA[3:0]: v = s.divisor_extra_reg[c];
                OFF_PIN_STATUS[3:0]: begin
                    v[PST_CTS] = ~s.sync_s[SY_CTS + int'(c)];
                    v[PST_DSR] = ~s.sync_s[SY_DSR + int'(c)];
                    v[PST_CD] = ~s.sync_s[SY_CD + int'(c)];
                    v[PST_RI] = ~s.sync_s[SY_RI + int'(c)];
                    v[PST_RX] = s.sync_s[SY_RX + int'(c)];
                end
                default: v = 8'h00;
            endcase
        end
        reg_read = {24'h00_0000, v};
    endfunction

    // Reset pin polarity follows the synchronised bus style.
    assign dev_pin_active = st_q.sync_s[SY_BUS_SEL] ? st_q.sync_s[SY_DEV_RST] : ~st_q.sync_s[SY_DEV_RST]; // R13

    // Next state: synchronisers, reset filter, APB slave and pin logic.
    always_comb begin
        logic c;
        c = I_PADDR[4];
        st_d = st_q;
        // The first stage feeds only the second; all logic reads the second.
        st_d.sync_m = {I_BUS_SEL, I_DEV_RESET, I_SERIAL_IN, I_RING_INDICATOR_N, I_CARRIER_DETECT_N,
                       I_SET_READY_N, I_CLEAR_TO_SEND_N}; // R16
        st_d.sync_s = st_q.sync_m; // R16
        st_d.strobe_pair = st_q.sync_s[SY_BUS_SEL]; // R12

        // Pulses shorter than the minimum width are filtered out as glitches.
        if (dev_pin_active) begin
            st_d.rst_cnt = (st_q.rst_cnt >= RST_MIN_CYC) ? st_q.rst_cnt : st_q.rst_cnt + 3'd1;
        end else begin
            st_d.rst_cnt = 3'd0;
        end
        st_d.dev_rst = (st_d.rst_cnt >= RST_MIN_CYC); // R14

        // Zero wait slave: data and ready are prepared in the setup cycle.
        st_d.pready = 1'b0;
        st_d.pslverr = 1'b0;
        if (I_PSEL && !I_PENABLE) begin
            st_d.pready = 1'b1;
            st_d.pslverr = !addr_ok(I_PADDR);
            st_d.prdata = I_PWRITE ? 32'h0000_0000 : reg_read(st_q, I_PADDR);
        end
        if (I_PSEL && I_PENABLE && st_q.pready && I_PWRITE && addr_ok(I_PADDR) && I_PADDR < OFF_SYS_STATUS) begin
            case (I_PADDR[3:0])
                OFF_MODEM_CTRL[3:0]: st_d.modem_control_reg[c] = I_PWDATA[7:0];
                OFF_FEATURE[3:0]: st_d.enhanced_feature_reg[c] = I_PWDATA[7:0];
                OFF_DIV_EXTRA[3:0]: st_d.divisor_extra_reg[c] = I_PWDATA[7:0];
                default: st_d.modem_control_reg = st_d.modem_control_reg;
            endcase
        end
        // Device reset wins over a write in the same cycle.
        if (st_q.dev_rst) begin
            st_d.modem_control_reg = {2{RST_MODEM_CTRL}}; // R14
            st_d.enhanced_feature_reg = {2{RST_FEATURE}}; // R14
            st_d.divisor_extra_reg = {2{RST_DIV_EXTRA}}; // R14
        end

        // Pin logic for both channels.
        for (int i = 0; i < 2; i++) begin
            if (st_q.dev_rst) begin
                st_d.tx[i] = 1'b1; // R15
                st_d.rxd[i] = 1'b1; // R15
                st_d.irq_oe[i] = 1'b0;
                st_d.irq[i] = 1'b0;
                st_d.gp_n[i] = 1'b1;
                st_d.rts_n[i] = 1'b1;
                st_d.dtr_n[i] = 1'b1;
                st_d.tx_permit[i] = 1'b0;
            end else begin
                // Infrared sends a pulse for each zero bit, so its line rests low.
                if (st_q.modem_control_reg[i][MCR_IR_MODE]) begin
                    st_d.tx[i] = I_TX_ACTIVE[i] & ~I_TX_BIT[i]; // R5
                    st_d.rxd[i] = ~(st_q.sync_s[SY_RX + i] ^ st_q.divisor_extra_reg[i][DLD_RX_INV]); // R7
                end else begin
                    st_d.tx[i] = ~I_TX_ACTIVE[i] | I_TX_BIT[i]; // R4
                    st_d.rxd[i] = st_q.sync_s[SY_RX + i]; // R6
                end
                // Interrupt pin and general output port share one enable bit.
                st_d.irq_oe[i] = st_q.modem_control_reg[i][MCR_IRQ_EN]; // R1 R2
                st_d.irq[i] = st_q.modem_control_reg[i][MCR_IRQ_EN] & I_IRQ_REQ[i]; // R1
                st_d.gp_n[i] = ~st_q.modem_control_reg[i][MCR_IRQ_EN]; // R1 R2 R3
                // Half duplex steering overrides flow control on the same pin.
                if (st_q.divisor_extra_reg[i][DLD_HDX]) begin
                    st_d.rts_n[i] = ~I_TX_ACTIVE[i]; // R9
                end else if (st_q.enhanced_feature_reg[i][EFR_AUTO_RTS]) begin
                    st_d.rts_n[i] = ~(st_q.modem_control_reg[i][MCR_RTS] & ~I_RX_HALT[i]); // R8
                end else begin
                    st_d.rts_n[i] = ~st_q.modem_control_reg[i][MCR_RTS];
                end
                st_d.dtr_n[i] = ~st_q.modem_control_reg[i][MCR_DTR]; // R11
                st_d.tx_permit[i] = ~st_q.enhanced_feature_reg[i][EFR_AUTO_CTS] | ~st_q.sync_s[SY_CTS + i]; // R10
            end
        end
    end

    // One register for the whole state; block reset loads constants only.
    always_ff @(posedge I_MCLK) begin
        if (!I_RESET_N) begin
            st_q <= '0;
            st_q.sync_m <= SYNC_RST;
            st_q.sync_s <= SYNC_RST;
            st_q.strobe_pair <= 1'b1;
            st_q.tx <= 2'b11;
            st_q.rxd <= 2'b11;
            st_q.gp_n <= 2'b11;
            st_q.rts_n <= 2'b11;
            st_q.dtr_n <= 2'b11;
        end else begin
            st_q <= st_d;
        end
    end

    // Every output is a flip-flop of the state.
    assign O_PRDATA = st_q.prdata;
    assign O_PREADY = st_q.pready;
    assign O_PSLVERR = st_q.pslverr;
    assign O_RX_DATA = st_q.rxd;
    assign O_TX_PERMIT = st_q.tx_permit;
    assign O_SERIAL_OUT = st_q.tx;
    assign O_IRQ_OUT_CHAN = st_q.irq;
    assign O_IRQ_OUT_CHAN_OE = st_q.irq_oe;
    assign O_GP_OUT_PORT_CHAN_N = st_q.gp_n;
    assign O_REQUEST_TO_SEND_N = st_q.rts_n;
    assign O_TERMINAL_READY_N = st_q.dtr_n;
    assign O_BUS_STROBE_PAIR = st_q.strobe_pair;
    assign O_DEV_RESET_ACTIVE = st_q.dev_rst;

    // Checks on the pin behaviour.
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RESET_N);

    irq_enable_on_a: assert property ((st_q.modem_control_reg[0][MCR_IRQ_EN] && !st_q.dev_rst) |=>
        (O_IRQ_OUT_CHAN_OE[0] && !O_GP_OUT_PORT_CHAN_N[0])) else $error("irq enable set but pin not driven"); // R1
    irq_enable_off_a: assert property ((!st_q.modem_control_reg[1][MCR_IRQ_EN]) |=>
        (!O_IRQ_OUT_CHAN_OE[1] && O_GP_OUT_PORT_CHAN_N[1])) else $error("irq enable clear but pin driven"); // R2
    std_idle_high_a: assert property ((!st_q.modem_control_reg[0][MCR_IR_MODE] && !I_TX_ACTIVE[0]) |=>
        O_SERIAL_OUT[0]) else $error("standard mode idle line not high"); // R4
    ir_idle_low_a: assert property ((st_q.modem_control_reg[1][MCR_IR_MODE] && !I_TX_ACTIVE[1] && !st_q.dev_rst) |=>
        !O_SERIAL_OUT[1]) else $error("infrared idle line not low"); // R5
    ir_rx_invert_a: assert property ((st_q.modem_control_reg[0][MCR_IR_MODE] && !st_q.dev_rst) |=>
        (O_RX_DATA[0] == !($past(st_q.sync_s[SY_RX]) ^ $past(st_q.divisor_extra_reg[0][DLD_RX_INV]))))
        else $error("infrared receive polarity wrong"); // R7
    hdx_direction_a: assert property ((st_q.divisor_extra_reg[0][DLD_HDX] && !st_q.dev_rst) |=>
        (O_REQUEST_TO_SEND_N[0] == !$past(I_TX_ACTIVE[0]))) else $error("half duplex direction wrong"); // R9
    cts_gating_a: assert property ((st_q.enhanced_feature_reg[1][EFR_AUTO_CTS] && st_q.sync_s[SY_CTS + 1] && !st_q.dev_rst) |=>
        !O_TX_PERMIT[1]) else $error("transmit allowed while clear to send inactive"); // R10
    dtr_follow_a: assert property ((!st_q.dev_rst) |=>
        (O_TERMINAL_READY_N[0] == !$past(st_q.modem_control_reg[0][MCR_DTR]))) else $error("terminal ready wrong"); // R11
    bus_style_a: assert property ((I_BUS_SEL [*3]) |=> O_BUS_STROBE_PAIR) else $error("bus style not followed"); // R12
    rst_pulse_a: assert property (((I_DEV_RESET && I_BUS_SEL) [*5]) |-> O_DEV_RESET_ACTIVE)
        else $error("held reset pin not honoured"); // R13 R16
    rst_clears_a: assert property (st_q.dev_rst |=> (st_q.modem_control_reg == '0 && st_q.enhanced_feature_reg == '0 && st_q.divisor_extra_reg == '0))
        else $error("registers not cleared by reset"); // R14
    rst_tx_high_a: assert property (st_q.dev_rst |=> (O_SERIAL_OUT == 2'b11 && O_RX_DATA == 2'b11))
        else $error("serial lines not idle in reset"); // R15

endmodule

// ==== verif/upmc_remote.sv ====
// Behavioural model of the remote serial equipment facing both channels.
`timescale 1ns/1ns
module upmc_remote (
    // Commands from the bench.
    input wire logic [1:0] i_ir_mode,
    input wire logic [1:0] i_send,
    input wire logic [1:0] i_bit,
    input wire logic [7:0] i_modem_n,
    // Lines into the device; modem group order is clear, set ready, carrier, ring.
    output logic [1:0] o_serial_in,
    output logic [7:0] o_modem_n
);
    // Between characters the line rests at the idle level of the chosen mode.
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            o_serial_in[c] = i_send[c] ? i_bit[c] : ~i_ir_mode[c];
        end
    end
    // Handshake lines are plain levels, so the bench can test every combination.
    assign o_modem_n = i_modem_n;
endmodule

// ==== verif/uart_pin_mode_control_tb_top.sv ====
// Self-checking bench for the serial pin and mode control block.
`timescale 1ns/1ns
module uart_pin_mode_control_tb_top;
    import upmc_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic bus_sel = 1'b1, dev_rst = 1'b0;
    logic [1:0] tx_bit = 2'b11, tx_act = 2'b00, irq_req = 2'b00, rx_halt = 2'b00;
    logic [1:0] ir = 2'b00, send = 2'b00, sbit = 2'b11;
    logic [7:0] modem_n = 8'hFF;
    wire [1:0] sin, rxd, permit, sout, irq_o, irq_oe, gp_n, rts_n, dtr_n;
    wire [7:0] mdm;
    wire [31:0] prdata;
    wire pready, pslverr, strobe, dev_act;
    logic [7:0] regs [6];
    logic [31:0] rd;
    logic er;
    logic [6:0] ev;
    int err_total = 0, samples_checked = 0, cyc = 0, seed = 30855;

    always #10 clk = ~clk;

    // A hang ends the run as a failure.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            err_total = err_total + 1;
            close_out();
        end
    end

    upmc_top DUT (.I_MCLK(clk), .I_RESET_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
        .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .I_BUS_SEL(bus_sel), .I_DEV_RESET(dev_rst), .I_TX_BIT(tx_bit), .I_TX_ACTIVE(tx_act),
        .I_IRQ_REQ(irq_req), .I_RX_HALT(rx_halt), .O_RX_DATA(rxd), .O_TX_PERMIT(permit),
        .O_SERIAL_OUT(sout), .I_SERIAL_IN(sin), .O_IRQ_OUT_CHAN(irq_o), .O_IRQ_OUT_CHAN_OE(irq_oe),
        .O_GP_OUT_PORT_CHAN_N(gp_n), .O_REQUEST_TO_SEND_N(rts_n), .I_CLEAR_TO_SEND_N(mdm[1:0]),
        .O_TERMINAL_READY_N(dtr_n), .I_SET_READY_N(mdm[3:2]), .I_CARRIER_DETECT_N(mdm[5:4]),
        .I_RING_INDICATOR_N(mdm[7:6]), .O_BUS_STROBE_PAIR(strobe), .O_DEV_RESET_ACTIVE(dev_act));

    upmc_remote remote (.i_ir_mode(ir), .i_send(send), .i_bit(sbit), .i_modem_n(modem_n),
        .o_serial_in(sin), .o_modem_n(mdm));

    task automatic close_out();
        if (err_total == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", nm, exp, got);
            err_total++;
        end
    endtask

    // One APB transfer; an idle edge follows so the strobes are never reassigned in one step.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    // Pin levels of one channel: tx, rx, rts_n, dtr_n, permit, irq enable, port_n.
    function automatic logic [6:0] expect_pins(input logic [7:0] m, e, d, input logic ta, tb, hl, si, ct);
        logic tx, rx, rts;
        tx = m[MCR_IR_MODE] ? (ta & ~tb) : (~ta | tb);
        rx = m[MCR_IR_MODE] ? ~(si ^ d[DLD_RX_INV]) : si;
        rts = d[DLD_HDX] ? ~ta : (e[EFR_AUTO_RTS] ? ~(m[MCR_RTS] & ~hl) : ~m[MCR_RTS]);
        return {tx, rx, rts, ~m[MCR_DTR], ~e[EFR_AUTO_CTS] | ~ct, m[MCR_IRQ_EN], ~m[MCR_IRQ_EN]};
    endfunction

    initial begin
        repeat (6) @(posedge clk);
        chk("reset pins", 32'h0000_03CF, 32'({sout, gp_n, irq_oe, rts_n, dtr_n}));
        rst_n <= 1'b1;
        @(posedge clk);
        // First two passes are the all-clear and all-set corners, the rest random.
        for (int it = 0; it < 40; it++) begin
            {tx_bit, tx_act, irq_req, rx_halt} <= 8'($random(seed));
            {send, sbit, modem_n} <= 12'($random(seed));
            // Control is written before the auto features, and the port is never used freely.
            for (int k = 0; k < 6; k++) begin
                regs[k] = it == 0 ? 8'h00 : it == 1 ? 8'hFF : 8'($random(seed));
                if (k % 3 == 1 && !regs[k - 1][MCR_RTS]) regs[k][EFR_AUTO_RTS] = 1'b0;
                apb(1'b1, 8'((k / 3) * 16 + (k % 3) * 4), {24'h0000_00, regs[k]});
            end
            ir <= {regs[3][MCR_IR_MODE], regs[0][MCR_IR_MODE]};
            repeat (5) @(posedge clk);
            for (int c = 0; c < 2; c++) begin
                ev = expect_pins(regs[c * 3], regs[c * 3 + 1], regs[c * 3 + 2], tx_act[c], tx_bit[c],
                    rx_halt[c], sin[c], mdm[c]);
                chk("pins", 32'(ev), 32'({sout[c], rxd[c], rts_n[c], dtr_n[c], permit[c], irq_oe[c], gp_n[c]}));
                if (regs[c * 3][MCR_IRQ_EN]) chk("irq", 32'(irq_req[c]), 32'(irq_o[c]));
                for (int k = 0; k < 3; k++) begin
                    apb(1'b0, 8'(c * 16 + k * 4), 32'h0000_0000);
                    chk("readback", {24'h0000_00, regs[c * 3 + k]}, rd);
                end
                apb(1'b0, 8'(c * 16 + 12), 32'h0000_0000);
                chk("status", 32'({sin[c], ~mdm[6 + c], ~mdm[4 + c], ~mdm[2 + c], ~mdm[c]}), rd);
                chk("slverr", 32'h0000_0000, 32'(er));
            end
        end
        apb(1'b0, OFF_SYS_STATUS, 32'h0000_0000);
        chk("system", 32'h0000_0001, rd);
        apb(1'b0, 8'h24, 32'h0000_0000);
        chk("unmapped", 32'h0000_0001, {rd[30:0], er});
        // Infrared idle with interrupt enabled, then a device reset in the strobe-pair style.
        tx_act <= 2'b00;
        apb(1'b1, OFF_MODEM_CTRL, 32'h0000_0048);
        repeat (2) @(posedge clk);
        chk("ir idle", 32'h0000_0001, 32'({sout[0], gp_n[0], irq_oe[0]}));
        dev_rst <= 1'b1;
        repeat (6) @(posedge clk);
        chk("dev reset", 32'h0000_000E, 32'({dev_act, sout[0], gp_n[0], irq_oe[0]}));
        dev_rst <= 1'b0;
        repeat (5) @(posedge clk);
        apb(1'b0, OFF_MODEM_CTRL, 32'h0000_0000);
        chk("cleared", 32'h0000_0000, rd);
        // A pulse of exactly the minimum width must still clear the registers.
        apb(1'b1, OFF_MODEM_CTRL, 32'h0000_0001);
        dev_rst <= 1'b1;
        repeat (2) @(posedge clk);
        dev_rst <= 1'b0;
        repeat (6) @(posedge clk);
        apb(1'b0, OFF_MODEM_CTRL, 32'h0000_0000);
        chk("short reset", 32'h0000_0000, rd);
        // Direction-select style: a high reset pin is idle, a low one resets.
        bus_sel <= 1'b0;
        dev_rst <= 1'b1;
        repeat (6) @(posedge clk);
        chk("low style idle", 32'h0000_0000, 32'({strobe, dev_act}));
        dev_rst <= 1'b0;
        repeat (6) @(posedge clk);
        chk("low style reset", 32'h0000_0001, 32'({strobe, dev_act}));
        close_out();
    end
endmodule
